// ---- verilog/pop_pkg.sv ----
`default_nettype none
package pop_pkg;

  // ==========================================================
  // pixel and table geometry
  localparam int           PIX_W      = 10;
  localparam int           LUT_DEPTH  = 1024;
  localparam int           LUT_NUM    = 3;
  localparam int           LUT_WORDS  = LUT_NUM * LUT_DEPTH;
  localparam int           LUT_AW     = 12;
  localparam int           FIFO_DEPTH = 8;
  localparam logic [10:0]  INV_CONST  = 11'h400;
  localparam logic [3:0]   SHIFT_MIN  = 4'h1;
  localparam logic [3:0]   SHIFT_MAX  = 4'h9;

  // ==========================================================
  // register map
  localparam int           AXI_AW       = 12;
  localparam logic [11:0]  REG_CTRL     = 12'h000;
  localparam logic [11:0]  REG_LUT_ADDR = 12'h004;
  localparam logic [11:0]  REG_LUT_DATA = 12'h008;
  localparam logic [11:0]  REG_STATUS   = 12'h00c;

  localparam int           CTRL_MODE_LSB  = 0;
  localparam int           CTRL_SHIFT_LSB = 4;
  localparam int           CTRL_TBL_LSB   = 8;
  localparam int           STAT_CNT_LSB   = 0;
  localparam int           STAT_BUSY_BIT  = 8;
  localparam logic [2:0]   CTRL_MODE_RST  = 3'h0;
  localparam logic [3:0]   CTRL_SHIFT_RST = 4'h1;
  localparam logic [1:0]   CTRL_TBL_RST   = 2'h0;
  localparam logic [1:0]   TBL_LAST       = 2'h2;

  localparam logic [1:0]   RESP_OKAY   = 2'b00;
  localparam logic [1:0]   RESP_SLVERR = 2'b10;

  // ==========================================================
  // transfer modes and pixel carrier
  typedef enum logic [2:0] {
    POP_BYPASS,
    POP_INVERT,
    POP_SHR,
    POP_INV_SHR,
    POP_SHL,
    POP_INV_SHL,
    POP_TABLE,
    POP_TEST
  } pop_mode_e;

  typedef struct packed {
    logic             sof;
    logic             sol;
    logic             eol;
    logic [PIX_W-1:0] data;
  } pop_pix_s;

  // ==========================================================
  // helpers
  function automatic logic [10:0] pop_invert(input logic [PIX_W-1:0] p);
    pop_invert = INV_CONST - {1'b0, p};
  endfunction

  function automatic logic [3:0] pop_clamp_shift(input logic [3:0] n);
    pop_clamp_shift = (n < SHIFT_MIN) ? SHIFT_MIN : ((n > SHIFT_MAX) ? SHIFT_MAX : n);
  endfunction

  function automatic logic [31:0] pop_strb_merge(input logic [31:0] old_v,
                                                 input logic [31:0] new_v,
                                                 input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    pop_strb_merge = (old_v & ~m) | (new_v & m);
  endfunction

endpackage
`default_nettype wire

// ---- verilog/pop_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module pop_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      cnt;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt != FULL_CNT);
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rd_ptr];
  assign level     = cnt;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt    <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- verilog/pop_preproc.sv ----
// Summary of operation
// - bypass mode passes each pixel value to the output unchanged.
// - invert mode outputs 1024 minus the pixel value, kept to 10 bits (pixel 0 gives 0).
// - right-shift mode shifts right by n (1..9), zero fill at top.
// - invert then right shift: 1024 minus pixel, shifted right by n.
// - left-shift mode shifts left by n (1..9), zero fill, top bits lost.
// - invert then left shift: 1024 minus pixel, shifted left by n.
// - table mode replaces pixel by entry it indexes in one of three tables.
// - test mode outputs a generated pattern instead of sensor data.
// - host can read back every entry of any table.
// - host can write tables; later table processing uses new entries.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module pop_preproc
  import pop_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  input  wire logic [AXI_AW-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [AXI_AW-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire pop_pix_s          PIX_IN,
  input  wire logic              PIX_IN_VALID,
  output logic                   PIX_IN_READY,
  output pop_pix_s               PIX_OUT,
  output logic                   PIX_OUT_VALID,
  input  wire logic              PIX_OUT_READY
);

  // ==========================================================
  // configuration and table storage
  pop_mode_e         ctrl_mode;
  logic [3:0]        ctrl_shift;
  logic [1:0]        ctrl_tbl;
  logic [LUT_AW-1:0] lut_addr;
  logic [PIX_W-1:0]  lut_mem [LUT_WORDS];

  // ==========================================================
  // axi4-lite slave state
  logic              aw_held;
  logic [AXI_AW-1:0] aw_addr_q;
  logic              w_held;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              rvalid;
  logic [31:0]       rdata;
  logic [1:0]        rresp;

  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY  = !w_held;
  assign S_AXI_BVALID  = bvalid;
  assign S_AXI_BRESP   = bresp;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_RVALID  = rvalid;
  assign S_AXI_RDATA   = rdata;
  assign S_AXI_RRESP   = rresp;

  wire do_write = aw_held && w_held && !bvalid;
  wire do_read  = S_AXI_ARVALID && !rvalid;
  wire wr_ctrl   = do_write && (aw_addr_q == REG_CTRL);
  wire wr_addr   = do_write && (aw_addr_q == REG_LUT_ADDR);
  wire wr_data   = do_write && (aw_addr_q == REG_LUT_DATA);
  wire wr_stat   = do_write && (aw_addr_q == REG_STATUS);
  wire wr_mapped = wr_ctrl || wr_addr || wr_data || wr_stat;
  wire rd_ctrl   = (S_AXI_ARADDR == REG_CTRL);
  wire rd_addr   = (S_AXI_ARADDR == REG_LUT_ADDR);
  wire rd_data   = (S_AXI_ARADDR == REG_LUT_DATA);
  wire rd_stat   = (S_AXI_ARADDR == REG_STATUS);
  wire rd_mapped = rd_ctrl || rd_addr || rd_data || rd_stat;

  // ==========================================================
  // register images and merges
  wire [31:0] ctrl_word = {22'h0, ctrl_tbl, ctrl_shift, 1'b0, ctrl_mode};
  wire [31:0] ctrl_new  = pop_strb_merge(ctrl_word, w_data_q, w_strb_q);
  wire [31:0] addr_word = {20'h0, lut_addr};
  wire [31:0] addr_new  = pop_strb_merge(addr_word, w_data_q, w_strb_q);
  wire             lut_ok      = (lut_addr < LUT_AW'(LUT_WORDS));
  wire [PIX_W-1:0] host_rd_val = lut_ok ? lut_mem[lut_addr] : '0;
  wire [31:0]      data_word   = {22'h0, host_rd_val};
  wire [31:0]      data_new    = pop_strb_merge(data_word, w_data_q, w_strb_q);
  wire [1:0] new_tbl = (ctrl_new[CTRL_TBL_LSB +: 2] > TBL_LAST) ? TBL_LAST : ctrl_new[CTRL_TBL_LSB +: 2];
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic                        s1_valid;
  logic                        s2_valid;
  wire  [31:0] stat_word = {23'h0, (s1_valid || s2_valid), 4'h0, fifo_level};

  wire [31:0] read_word = rd_ctrl ? ctrl_word :
                          rd_addr ? addr_word :
                          rd_data ? data_word :
                          rd_stat ? stat_word : 32'h0;

  // data port access moves the pointer, a pointer write wins
  wire [1:0] addr_steps = 2'(wr_data) + 2'(do_read && rd_data);
  wire [LUT_AW-1:0] next_lut_addr = wr_addr ? addr_new[LUT_AW-1:0] : lut_addr + LUT_AW'(addr_steps);

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
      w_held    <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_held)
      begin
        aw_held   <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (S_AXI_WVALID && !w_held)
      begin
        w_held   <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      else if (do_write)
        w_held <= 1'b0;
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end
    else if (do_read)
    begin
      rvalid <= 1'b1;
      rdata  <= read_word;
      rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
      rvalid <= 1'b0;
  end

  // ==========================================================
  // control registers
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctrl_mode  <= pop_mode_e'(CTRL_MODE_RST);
      ctrl_shift <= CTRL_SHIFT_RST;
      ctrl_tbl   <= CTRL_TBL_RST;
      lut_addr   <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_mode  <= pop_mode_e'(ctrl_new[CTRL_MODE_LSB +: 3]);
        ctrl_shift <= pop_clamp_shift(ctrl_new[CTRL_SHIFT_LSB +: 4]);
        ctrl_tbl   <= new_tbl;
      end
      lut_addr <= next_lut_addr;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (wr_data && lut_ok)
      lut_mem[lut_addr] <= data_new[PIX_W-1:0];
  end

  // ==========================================================
  // pixel pipeline: capture stage, compute stage, fifo
  pop_pix_s         s1_pix;
  pop_mode_e        s1_mode;
  logic [3:0]       s1_shift;
  logic [PIX_W-1:0] s1_lut;
  logic [PIX_W-1:0] s1_test;
  pop_pix_s         s2_pix;
  logic [PIX_W-1:0] col_cnt;
  logic [PIX_W-1:0] row_cnt;
  logic             fifo_in_ready;

  wire adv  = !s2_valid || fifo_in_ready;
  wire take = PIX_IN_VALID && adv;
  assign PIX_IN_READY = adv;

  wire [LUT_AW-1:0] lut_rd_idx = {ctrl_tbl, PIX_IN.data};
  wire [PIX_W-1:0]  lut_pix    = lut_mem[lut_rd_idx];

  // diagonal ramp from line and row position
  wire [PIX_W-1:0] tp_col  = PIX_IN.sol ? '0 : col_cnt;
  wire [PIX_W-1:0] tp_row  = PIX_IN.sof ? '0 : row_cnt;
  wire [PIX_W-1:0] tp_val  = tp_col + tp_row;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      col_cnt <= '0;
      row_cnt <= '0;
    end
    else if (take)
    begin
      col_cnt <= tp_col + 1'b1;
      row_cnt <= PIX_IN.eol ? tp_row + 1'b1 : tp_row;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s1_valid <= 1'b0;
      s1_pix   <= '0;
      s1_mode  <= POP_BYPASS;
      s1_shift <= CTRL_SHIFT_RST;
      s1_lut   <= '0;
      s1_test  <= '0;
    end
    else if (adv)
    begin
      s1_valid <= PIX_IN_VALID;
      s1_pix   <= PIX_IN;
      s1_mode  <= ctrl_mode;
      s1_shift <= ctrl_shift;
      s1_lut   <= lut_pix;
      s1_test  <= tp_val;
    end
  end
  wire [10:0]      inv_val   = pop_invert(s1_pix.data);
  wire [PIX_W-1:0] shr_val   = s1_pix.data >> s1_shift;
  wire [10:0]      inv_shr_w = inv_val >> s1_shift;
  wire [PIX_W-1:0] shl_val   = s1_pix.data << s1_shift;
  wire [10:0]      inv_shl_w = inv_val << s1_shift;
  wire [PIX_W-1:0] next_out =
    (s1_mode == POP_INVERT)  ? inv_val[PIX_W-1:0]   :
    (s1_mode == POP_SHR)     ? shr_val              :
    (s1_mode == POP_INV_SHR) ? inv_shr_w[PIX_W-1:0] :
    (s1_mode == POP_SHL)     ? shl_val              :
    (s1_mode == POP_INV_SHL) ? inv_shl_w[PIX_W-1:0] :
    (s1_mode == POP_TABLE)   ? s1_lut               :
    (s1_mode == POP_TEST)    ? s1_test              : s1_pix.data;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      s2_valid <= 1'b0;
      s2_pix   <= '0;
    end
    else if (adv)
    begin
      s2_valid <= s1_valid;
      s2_pix   <= '{sof: s1_pix.sof, sol: s1_pix.sol, eol: s1_pix.eol, data: next_out};
    end
  end

  pop_fifo #(
    .WIDTH ($bits(pop_pix_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_b     (RST_B),
    .in_valid  (s2_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (s2_pix),
    .out_valid (PIX_OUT_VALID),
    .out_ready (PIX_OUT_READY),
    .out_data  (PIX_OUT),
    .level     (fifo_level)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  wire s1_go = adv && s1_valid;

  a_bypass_pass:
    assert property (s1_go && s1_mode == POP_BYPASS |=> s2_pix.data == $past(s1_pix.data))
      else $error("bypass pixel altered");
  a_invert_value:
    assert property (s1_go && s1_mode == POP_INVERT
                     |=> s2_pix.data == 10'($past(INV_CONST) - {1'b0, $past(s1_pix.data)}))
      else $error("invert value wrong");
  a_shr_value:
    assert property (s1_go && s1_mode == POP_SHR |=> s2_pix.data == ($past(s1_pix.data) >> $past(s1_shift)))
      else $error("right shift wrong");
  a_inv_shr_value:
    assert property (s1_go && s1_mode == POP_INV_SHR && s1_pix.data == '0 && s1_shift == SHIFT_MIN
                     |=> s2_pix.data == 10'h200)
      else $error("invert right shift wrong");
  a_shl_value:
    assert property (s1_go && s1_mode == POP_SHL
                     |=> s2_pix.data == 10'($past(s1_pix.data) << $past(s1_shift)))
      else $error("left shift wrong");
  a_inv_shl_value:
    assert property (s1_go && s1_mode == POP_INV_SHL && s1_pix.data == 10'h3ff && s1_shift == SHIFT_MAX
                     |=> s2_pix.data == 10'h200)
      else $error("invert left shift wrong");
  a_shift_range:
    assert property (s1_shift >= SHIFT_MIN && s1_shift <= SHIFT_MAX && ctrl_tbl <= TBL_LAST)
      else $error("shift or table out of range");
  a_table_value:
    assert property (take && ctrl_mode == POP_TABLE && !wr_data
                     |=> ##1 s2_pix.data == $past(lut_pix, 2))
      else $error("table output wrong");
  a_test_value:
    assert property (s1_go && s1_mode == POP_TEST |=> s2_pix.data == $past(s1_test))
      else $error("test pattern wrong");
  a_table_readback:
    assert property (do_read && rd_data |=> S_AXI_RVALID && S_AXI_RDATA == {22'h0, $past(host_rd_val)})
      else $error("table readback wrong");
  a_table_store:
    assert property (wr_data && lut_ok && w_strb_q[1:0] == 2'b11
                     |=> lut_mem[$past(lut_addr)] == $past(w_data_q[PIX_W-1:0]))
      else $error("table write lost");
  a_marker_align:
    assert property (s1_go |=> s2_valid && s2_pix[12:10] == $past(s1_pix[12:10]))
      else $error("markers misaligned");
  a_write_answer:
    assert property (do_write |=> S_AXI_BVALID)
      else $error("write not answered");

  c_table_mode: cover property (s1_go && s1_mode == POP_TABLE);
  c_test_mode:  cover property (s1_go && s1_mode == POP_TEST);
  c_fifo_full:  cover property (!fifo_in_ready && s2_valid);
  c_readback:   cover property (do_read && rd_data ##1 S_AXI_RVALID);

endmodule
`default_nettype wire

// ---- tb/pop_sink.sv ----
`timescale 1ns/1ns
`default_nettype none
module pop_sink
  import pop_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_b,
  input  wire pop_pix_s pix,
  input  wire logic     valid,
  input  wire logic     hold,
  input  wire logic     slow,
  output logic          ready
);
  pop_pix_s got [0:255];
  int       n_got;
  logic     ph;

  // slow mode takes a word every other cycle
  assign ready = !hold && !(slow && ph);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ph <= 1'b0;
      n_got <= 0;
    end
    else
    begin
      ph <= !ph;
      if (valid && ready)
      begin
        got[n_got[7:0]] <= pix;
        n_got <= n_got + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench
  import pop_pkg::*;
;
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, pvalid, hold, slow;
  logic        awready, wready, bvalid, arready, rvalid, pready, ovalid, oready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  pop_pix_s    pin, pout;
  int          err_total, n_checks, base;
  logic [9:0]  pv [4] = '{10'h000, 10'h001, 10'h201, 10'h3ff};

  pop_preproc u_pop_preproc (.REF_CLK(clk), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PIX_IN(pin), .PIX_IN_VALID(pvalid), .PIX_IN_READY(pready),
    .PIX_OUT(pout), .PIX_OUT_VALID(ovalid), .PIX_OUT_READY(oready));

  pop_sink u_pop_sink (.clk(clk), .rst_b(rst_b), .pix(pout), .valid(ovalid),
    .hold(hold), .slow(slow), .ready(oready));

  // ==========================================================
  // common tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int   k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    @(posedge clk);
    if (k == 200) chk(32'h1, 32'h0);
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int   k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 200; k++)
    begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    rready <= 1'b0;
    @(posedge clk);
    if (k == 200) chk(32'h1, 32'h0);
  endtask

  // leaves valid high so words can follow back to back
  task automatic push(input logic [12:0] w);
    logic t;
    int   k;
    pin <= pop_pix_s'(w);
    pvalid <= 1'b1;
    for (k = 0; k < 100; k++)
    begin
      @(negedge clk);
      t = pready;
      @(posedge clk);
      if (t) break;
    end
  endtask

  task automatic drain(input int want);
    int k;
    for (k = 0; k < 500 && u_pop_sink.n_got < want; k++) @(posedge clk);
    if (k == 500) chk(32'h1, 32'h0);
  endtask

  function automatic logic [9:0] expv(input int m, input int n, input logic [9:0] p);
    logic [10:0] iv;
    iv = 11'h400 - {1'b0, p};
    case (m)
      1: return iv[9:0];
      2: return p >> n;
      3: return 10'(iv >> n);
      4: return p << n;
      5: return 10'(iv << n);
      default: return p;
    endcase
  endfunction

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axr(REG_CTRL, d, r);
    chk(d, 32'h10);
    axw(REG_CTRL, 32'h300, r);
    axr(REG_CTRL, d, r);
    chk(d, 32'h210);
    axw(12'h040, 32'h5, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axr(12'h040, d, r);
    chk({d[29:0], r}, 32'(RESP_SLVERR));
    axw(REG_STATUS, 32'hffff, r);
    axr(REG_STATUS, d, r);
    chk({d[29:0], r}, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_modes;
    logic [1:0] r;
    for (int m = 0; m < 6; m++)
      for (int n = 1; n <= 9; n += 8)
      begin
        axw(REG_CTRL, 32'((n << 4) | m), r);
        foreach (pv[i]) push({3'h0, pv[i]});
        pvalid <= 1'b0;
        drain(base + 4);
        foreach (pv[i]) chk(32'(u_pop_sink.got[base + i]), {22'h0, expv(m, n, pv[i])});
        base += 4;
      end
    $display("test modes done");
  endtask

  task automatic t_table;
    logic [31:0] d;
    logic [1:0]  r;
    axw(REG_LUT_ADDR, 32'h400, r);
    for (int i = 0; i < 4; i++) axw(REG_LUT_DATA, 32'(32'h300 + i * 17), r);
    axw(REG_LUT_ADDR, 32'h800, r);
    axw(REG_LUT_DATA, 32'h155, r);
    axw(REG_LUT_ADDR, 32'h400, r);
    for (int i = 0; i < 4; i++)
    begin
      axr(REG_LUT_DATA, d, r);
      chk(d, 32'(32'h300 + i * 17));
    end
    axr(REG_LUT_ADDR, d, r);
    chk(d, 32'h404);
    slow <= 1'b1;
    axw(REG_CTRL, 32'h116, r);
    for (int i = 0; i < 4; i++) push(13'(i));
    pvalid <= 1'b0;
    axw(REG_CTRL, 32'h216, r);
    push(13'h0);
    pvalid <= 1'b0;
    drain(base + 5);
    for (int i = 0; i < 4; i++) chk(32'(u_pop_sink.got[base + i]), 32'(32'h300 + i * 17));
    chk(32'(u_pop_sink.got[base + 4]), 32'h155);
    base += 5;
    slow <= 1'b0;
    $display("test table done");
  endtask

  task automatic t_image;
    logic [12:0] wi [4] = '{13'h1805, 13'h0007, 13'h0403, 13'h0801};
    logic [12:0] wo [4] = '{13'h1800, 13'h0001, 13'h0402, 13'h0801};
    logic [1:0]  r;
    axw(REG_CTRL, 32'h17, r);
    foreach (wi[i]) push(wi[i]);
    pvalid <= 1'b0;
    drain(base + 4);
    foreach (wo[i]) chk(32'(u_pop_sink.got[base + i]), 32'(wo[i]));
    base += 4;
    $display("test image done");
  endtask

  task automatic t_fifo;
    logic [31:0] d;
    logic [1:0]  r;
    logic        t;
    int          acc;
    axw(REG_CTRL, 32'h10, r);
    hold <= 1'b1;
    acc = 0;
    pin <= pop_pix_s'(13'h0);
    pvalid <= 1'b1;
    for (int c = 0; c < 20; c++)
    begin
      @(negedge clk);
      t = pready;
      @(posedge clk);
      if (t) acc++;
      if (t) pin <= pop_pix_s'(13'(acc));
    end
    pvalid <= 1'b0;
    @(negedge clk);
    chk(32'(pready), 32'h0);
    @(posedge clk);
    axr(REG_STATUS, d, r);
    chk(32'(d[8:0]), 32'h100 | 32'(FIFO_DEPTH));
    hold <= 1'b0;
    drain(base + acc);
    for (int i = 0; i < acc; i++) chk(32'(u_pop_sink.got[base + i]), 32'(i));
    base += acc;
    axr(REG_STATUS, d, r);
    chk(d, 32'h0);
    $display("test fifo done, %0d words held", acc);
  endtask

  // ==========================================================
  // run control
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end

  initial
  begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, pvalid, hold, slow} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    pin = pop_pix_s'(13'h0);
    err_total = 0;
    n_checks = 0;
    base = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_table();
    t_image();
    t_fifo();
    tally_and_finish();
  end
endmodule
`default_nettype wire
